// file: rtl/rsc_pkg.sv
// constants and types for the radio spi command interpreter
package rsc_pkg;
	localparam logic [7:0] CMD_RD_REG = 8'h00;
	localparam logic [7:0] CMD_WR_REG = 8'h20;
	localparam logic [7:0] CMD_RD_RX = 8'h61;
	localparam logic [7:0] CMD_RD_WID = 8'h60;
	localparam logic [7:0] CMD_WR_TX = 8'hA0;
	localparam logic [7:0] CMD_WR_ACK = 8'hA8;
	localparam logic [7:0] CMD_WR_NOACK = 8'hB0;
	localparam logic [7:0] CMD_FLUSH_TX = 8'hE1;
	localparam logic [7:0] CMD_FLUSH_RX = 8'hE2;
	localparam logic [7:0] CMD_REUSE = 8'hE3;
	localparam logic [7:0] CMD_ACTIVATE = 8'h50;
	localparam logic [7:0] CMD_NOP = 8'hFF;
	localparam logic [7:0] ACT_FEATURES = 8'h73;
	localparam logic [7:0] ACT_BANK = 8'h53;
	localparam logic [4:0] REG_CONFIG = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h07;
	localparam logic [4:0] REG_FIFO_ST = 5'h17;
	localparam logic [4:0] BANK1_MSB_LAST = 5'h08;
	localparam logic [7:0] CONFIG_RESET = 8'h08;
	localparam int MASK_RX_BIT = 6;
	localparam int MASK_TX_BIT = 5;
	localparam int MASK_RT_BIT = 4;
	localparam int PWR_UP_BIT = 1;
	localparam logic [2:0] PIPE_EMPTY = 3'h7;
	localparam logic [2:0] PIPE_MAX = 3'h5;
	localparam int REG_BYTES = 5;
	localparam int PAYLOAD_BYTES = 32;
	localparam int QUEUE_DEPTH = 3;
	typedef enum logic [1:0] {RSC_IDLE, RSC_CMD, RSC_DATA} rsc_phase_t;
endpackage : rsc_pkg

// file: rtl/rsc_queue.sv
// three-level payload queue with per-entry length and tag
`timescale 1ns/1ps
`default_nettype none
module rsc_queue
	import rsc_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH,
	parameter int BYTES = PAYLOAD_BYTES
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic wr_byte,
	input wire logic [7:0] wr_data,
	input wire logic wr_commit,
	input wire logic [3:0] wr_tag,
	input wire logic rd_pop,
	input wire logic [4:0] rd_index,
	input wire logic flush,
	output logic [7:0] rd_data,
	output logic [5:0] head_len,
	output logic [3:0] head_tag,
	output logic empty,
	output logic full
);
	// pointers and count are two bits wide, byte indices five
	if (DEPTH < 1 || DEPTH > 3 || BYTES < 1 || BYTES > 32)
	begin : g_size_check
		$error("rsc_queue serves 1 to 3 entries of 1 to 32 bytes");
	end
	logic [7:0] mem_q [DEPTH][BYTES];
	logic [5:0] len_q [DEPTH];
	logic [3:0] tag_q [DEPTH];
	logic [1:0] head_q, tail_q, count_q;
	logic [5:0] fill_q;
	wire [1:0] tail_next = (tail_q == 2'(DEPTH - 1)) ? 2'd0 : tail_q + 2'd1;
	wire [1:0] head_next = (head_q == 2'(DEPTH - 1)) ? 2'd0 : head_q + 2'd1;
	wire do_push = wr_commit && !full && fill_q != 6'd0;
	wire do_pop = rd_pop && !empty;
	assign empty = count_q == 2'd0;
	assign full = count_q == 2'(DEPTH);
	always_ff @(posedge clock)
	begin
		if (wr_byte && !full && fill_q < 6'(BYTES))
			mem_q[tail_q][fill_q[4:0]] <= wr_data;
	end
	always_ff @(posedge clock)
	begin
		if (rst || flush)
		begin
			head_q <= 2'd0;
			tail_q <= 2'd0;
			count_q <= 2'd0;
			fill_q <= 6'd0;
		end
		else
		begin
			if (wr_byte && !full && fill_q < 6'(BYTES))
				fill_q <= fill_q + 6'd1;
			if (do_push)
			begin
				len_q[tail_q] <= fill_q;
				tag_q[tail_q] <= wr_tag;
				tail_q <= tail_next;
				fill_q <= 6'd0;
			end
			else if (wr_commit)
				fill_q <= 6'd0;
			if (do_pop)
				head_q <= head_next;
			count_q <= count_q + 2'(do_push) - 2'(do_pop);
		end
	end
	always_ff @(posedge clock)
	begin
		rd_data <= mem_q[head_q][rd_index];
		head_len <= empty ? 6'd0 : len_q[head_q];
		head_tag <= empty ? 4'd0 : tag_q[head_q];
	end
endmodule : rsc_queue
`default_nettype wire

// file: rtl/rsc_spi_core.sv
// spi command interpreter with registers, payload queues and interrupt
`timescale 1ns/1ps
`default_nettype none
module rsc_spi_core
	import rsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic sck,
	input wire logic csn,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	output logic irq_n,
	input wire logic ev_sent,
	input wire logic ev_received,
	input wire logic [2:0] ev_pipe,
	input wire logic ev_retry_limit,
	input wire logic radio_idle,
	input wire logic tx_pop,
	input wire logic rx_byte,
	input wire logic [7:0] rx_byte_data,
	input wire logic rx_commit,
	input wire logic [5:0] pipe_lost,
	output logic [7:0] tx_head_data,
	input wire logic [4:0] tx_head_index,
	output logic [5:0] tx_head_len,
	output logic tx_head_noack,
	output logic [2:0] tx_head_pipe,
	output logic tx_ready,
	output logic tx_stalled,
	output logic reuse_active,
	output logic radio_hold,
	output logic features_on,
	output logic bank_sel,
	output logic [7:0] config_out
);
	// pin synchronisers; first stage read only by the second
	logic [2:0] sck_s1_q, sck_s2_q;
	logic sck_s3_q;
	always_ff @(posedge clock)
	begin
		sck_s1_q <= {sck, csn, mosi};
		sck_s2_q <= sck_s1_q;
		sck_s3_q <= sck_s2_q[2];
	end
	wire sck_sync = sck_s2_q[2];
	wire csn_sync = sck_s2_q[1];
	wire mosi_sync = sck_s2_q[0];
	wire sck_rise = sck_sync && !sck_s3_q;
	wire sck_fall = !sck_sync && sck_s3_q;
	rsc_phase_t phase_q;
	logic [7:0] shin_q, shout_q, cmd_q;
	logic [2:0] bit_q;
	logic [5:0] byte_q;
	logic [7:0] config_q;
	logic sent_q, recv_q, retry_q;
	logic [2:0] pipe_q;
	logic reuse_q, feat_q, bank_q;
	logic [39:0] regs_q [32];
	logic irq_q;
	wire [7:0] rx_data, tx_data_unused;
	wire [5:0] rx_len;
	wire [3:0] rx_tag, tx_tag;
	wire rx_empty, rx_full, tx_empty, tx_full;
	wire byte_done = sck_rise && bit_q == 3'd7;
	wire [7:0] byte_in = {shin_q[6:0], mosi_sync};
	wire [7:0] status_byte = {bank_q, recv_q, sent_q, retry_q, pipe_q, tx_full};
	wire [7:0] fifo_byte = {1'b0, reuse_q, tx_full, tx_empty, 2'b00, rx_full,
		rx_empty};
	wire standby = !config_q[PWR_UP_BIT] || radio_idle;
	wire in_data = phase_q == RSC_DATA;
	wire is_rd_reg = cmd_q[7:5] == CMD_RD_REG[7:5];
	wire is_wr_reg = cmd_q[7:5] == CMD_WR_REG[7:5];
	wire is_ack_wr = cmd_q[7:3] == CMD_WR_ACK[7:3] &&
		cmd_q[2:0] <= PIPE_MAX;
	wire is_tx_wr = cmd_q == CMD_WR_TX || (feat_q && cmd_q == CMD_WR_NOACK) ||
		(feat_q && is_ack_wr);
	wire [4:0] addr = cmd_q[4:0];
	// bank one low registers send their bytes most significant first
	wire msb_first = bank_q && addr <= BANK1_MSB_LAST;
	wire [2:0] lane = msb_first ? 3'(REG_BYTES - 1) - byte_q[2:0] :
		byte_q[2:0];
	wire [39:0] reg_word = addr == REG_STATUS ? {32'h0000_0000, status_byte} :
		addr == REG_CONFIG ? {32'h0000_0000, config_q} :
		addr == REG_FIFO_ST ? {32'h0000_0000, fifo_byte} : regs_q[addr];
	wire [7:0] reg_lane = byte_q < 6'(REG_BYTES) ? reg_word[lane * 8 +: 8] :
		8'h00;
	wire [7:0] next_out = is_rd_reg ? reg_lane :
		cmd_q == CMD_RD_RX ? rx_data :
		(cmd_q == CMD_RD_WID && feat_q) ? {2'b00, rx_len} : 8'h00;
	wire wr_ok = in_data && byte_done && is_wr_reg && standby;
	wire act_byte = in_data && byte_done && cmd_q == CMD_ACTIVATE &&
		byte_q == 6'd0 && standby;
	wire tx_byte_wr = in_data && byte_done && is_tx_wr;
	wire cmd_end = csn_sync && phase_q != RSC_IDLE;
	wire tx_commit = cmd_end && is_tx_wr;
	wire rx_read_end = cmd_end && cmd_q == CMD_RD_RX && byte_q != 6'd0;
	wire cmd_taken = phase_q == RSC_CMD && byte_done;
	wire [7:0] new_cmd = byte_in;
	wire flush_tx = cmd_taken && new_cmd == CMD_FLUSH_TX;
	wire flush_rx = cmd_taken && new_cmd == CMD_FLUSH_RX;
	wire set_reuse = cmd_taken && new_cmd == CMD_REUSE;
	wire clear_reuse = flush_tx || tx_commit;
	wire [3:0] wr_tag = cmd_q == CMD_WR_NOACK ? 4'h8 :
		is_ack_wr ? {1'b0, cmd_q[2:0]} : 4'h0;
	wire [4:0] rd_idx = byte_q[4:0] + 5'(byte_done ? 1 : 0);
	wire clr_wr = wr_ok && addr == REG_STATUS && byte_q == 6'd0;
	wire [2:0] sflag = {ev_received, ev_sent, ev_retry_limit};
	wire [2:0] cflag = clr_wr ? byte_in[6:4] : 3'b000;
	wire irq_d = (recv_q && !config_q[MASK_RX_BIT]) ||
		(sent_q && !config_q[MASK_TX_BIT]) ||
		(retry_q && !config_q[MASK_RT_BIT]);
	rsc_queue #(.DEPTH(QUEUE_DEPTH), .BYTES(PAYLOAD_BYTES)) u_txq (
		.clock(clock),
		.rst(rst),
		.wr_byte(tx_byte_wr),
		.wr_data(byte_in),
		.wr_commit(tx_commit),
		.wr_tag(wr_tag),
		.rd_pop(tx_pop && !reuse_q && !retry_q),
		.rd_index(tx_head_index),
		.flush(flush_tx),
		.rd_data(tx_data_unused),
		.head_len(tx_head_len),
		.head_tag(tx_tag),
		.empty(tx_empty),
		.full(tx_full)
	);
	rsc_queue #(.DEPTH(QUEUE_DEPTH), .BYTES(PAYLOAD_BYTES)) u_rxq (
		.clock(clock),
		.rst(rst),
		.wr_byte(rx_byte),
		.wr_data(rx_byte_data),
		.wr_commit(rx_commit),
		.wr_tag({1'b0, ev_pipe}),
		.rd_pop(rx_read_end),
		.rd_index(rd_idx),
		.flush(flush_rx),
		.rd_data(rx_data),
		.head_len(rx_len),
		.head_tag(rx_tag),
		.empty(rx_empty),
		.full(rx_full)
	);
	assign tx_head_data = tx_data_unused;
	assign tx_head_noack = tx_tag[3];
	assign tx_head_pipe = tx_tag[2:0];
	// lost links only stall; a flush or the pipe_lost bit dropping ends the stall
	assign tx_stalled = !tx_empty && pipe_lost[tx_tag[2:0]];
	assign tx_ready = !tx_empty && !tx_stalled && !retry_q;
	assign reuse_active = reuse_q;
	assign radio_hold = retry_q;
	assign features_on = feat_q;
	assign bank_sel = bank_q;
	assign config_out = config_q;
	assign irq_n = !irq_q;
	assign miso = shout_q[7];
	assign miso_oe = !csn_sync;
	always_ff @(posedge clock)
	begin
		if (rst || csn_sync)
		begin
			phase_q <= csn_sync ? RSC_IDLE : RSC_CMD;
			bit_q <= 3'd0;
			byte_q <= 6'd0;
			cmd_q <= CMD_NOP;
			shin_q <= 8'h00;
		end
		else
		begin
			case (phase_q)
				RSC_IDLE: phase_q <= RSC_CMD;
				RSC_CMD:
					if (byte_done)
					begin
						cmd_q <= new_cmd;
						phase_q <= RSC_DATA;
					end
				RSC_DATA:
					if (byte_done)
						byte_q <= byte_q + 6'd1;
				default: phase_q <= RSC_IDLE;
			endcase
			if (sck_rise)
			begin
				shin_q <= byte_in;
				bit_q <= bit_q + 3'd1;
			end
		end
	end
	// status preloads on select fall and shifts with the command byte
	always_ff @(posedge clock)
	begin
		if (rst)
			shout_q <= 8'h00;
		else if (phase_q == RSC_IDLE)
			shout_q <= status_byte;
		else if (sck_fall && bit_q == 3'd0 && phase_q == RSC_DATA)
			shout_q <= next_out;
		else if (sck_fall)
			shout_q <= {shout_q[6:0], 1'b0};
	end
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			config_q <= CONFIG_RESET;
			feat_q <= 1'b0;
			bank_q <= 1'b0;
		end
		else
		begin
			if (wr_ok && addr == REG_CONFIG && byte_q == 6'd0)
				config_q <= byte_in;
			if (act_byte && byte_in == ACT_FEATURES)
				feat_q <= !feat_q;
			if (act_byte && byte_in == ACT_BANK)
				bank_q <= !bank_q;
		end
	end
	always_ff @(posedge clock)
	begin
		if (wr_ok && byte_q < 6'(REG_BYTES) && addr != REG_STATUS)
			regs_q[addr][lane * 8 +: 8] <= byte_in;
	end
	// hardware set wins over a same-cycle host clear
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			recv_q <= 1'b0;
			sent_q <= 1'b0;
			retry_q <= 1'b0;
			reuse_q <= 1'b0;
			irq_q <= 1'b0;
			pipe_q <= PIPE_EMPTY;
		end
		else
		begin
			recv_q <= sflag[2] || (recv_q && !cflag[2]);
			sent_q <= sflag[1] || (sent_q && !cflag[1]);
			retry_q <= sflag[0] || (retry_q && !cflag[0]);
			if (set_reuse)
				reuse_q <= 1'b1;
			else if (clear_reuse)
				reuse_q <= 1'b0;
			irq_q <= irq_d;
			if ((irq_d && !irq_q) || rx_empty)
				pipe_q <= rx_empty ? PIPE_EMPTY : rx_tag[2:0];
		end
	end
	a_irq_follows: assert property (
		@(posedge clock) disable iff (rst)
		irq_d |=> !irq_n)
		else $error("irq not asserted");
	a_mask_blocks: assert property (
		@(posedge clock) disable iff (rst)
		&config_q[6:4] |=> irq_n)
		else $error("masked irq asserted");
	a_recv_set: assert property (
		@(posedge clock) disable iff (rst)
		ev_received |=> recv_q)
		else $error("received flag lost its set");
	a_reuse_clear: assert property (
		@(posedge clock) disable iff (rst)
		flush_tx && !set_reuse |=> !reuse_q)
		else $error("reuse kept");
	a_reuse_commit: assert property (
		@(posedge clock) disable iff (rst)
		tx_commit && !set_reuse |=> !reuse_q)
		else $error("reuse kept after payload write");
	a_reuse_set: assert property (
		@(posedge clock) disable iff (rst)
		set_reuse |=> reuse_q)
		else $error("reuse not set");
	a_reuse_hold: assert property (
		@(posedge clock) disable iff (rst)
		reuse_q && !tx_empty && !flush_tx |=> !tx_empty)
		else $error("reused payload lost");
	a_retry_keep: assert property (
		@(posedge clock) disable iff (rst)
		retry_q && !tx_empty && !flush_tx |=> !tx_empty)
		else $error("payload lost");
	a_nop_status: assert property (
		@(posedge clock) disable iff (rst)
		phase_q == RSC_IDLE |=> shout_q == $past(status_byte))
		else $error("status not loaded");
	a_pipe_empty: assert property (
		@(posedge clock) disable iff (rst)
		rx_empty |=> pipe_q == PIPE_EMPTY)
		else $error("pipe field not empty code");
	a_flush_rx: assert property (
		@(posedge clock) disable iff (rst)
		flush_rx |=> rx_empty)
		else $error("rx not flushed");
	a_bank_toggle: assert property (
		@(posedge clock) disable iff (rst)
		act_byte && byte_in == ACT_BANK |=> bank_q != $past(bank_q))
		else $error("bank not toggled");
	a_act_gate: assert property (
		@(posedge clock) disable iff (rst)
		!standby |=> feat_q == $past(feat_q) && bank_q == $past(bank_q))
		else $error("activate while active");
	a_write_gate: assert property (
		@(posedge clock) disable iff (rst)
		!standby && !rst |=> config_q == $past(config_q))
		else $error("write while active");
endmodule : rsc_spi_core
`default_nettype wire

// file: sim/rsc_host.sv
// spi master model of the host controller
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
	input wire logic clock,
	output logic sck,
	output logic csn,
	output logic mosi,
	input wire logic miso
);
	logic [7:0] tx_b [0:32];
	logic [7:0] rx_b [0:32];
	initial
	begin
		sck = 1'b0;
		csn = 1'b1;
		mosi = 1'b0;
	end
	// four clocks a half period: the 320 ns link clock
	task automatic half();
		repeat (4) @(posedge clock);
	endtask : half
	// whole command in one select period; clock stands low outside
	task automatic xfer(input int n);
		@(posedge clock);
		csn <= 1'b0;
		mosi <= tx_b[0][7];
		for (int i = 0; i < n; i++)
		begin
			for (int b = 7; b >= 0; b--)
			begin
				half();
				sck <= 1'b1;
				rx_b[i][b] = miso;
				half();
				sck <= 1'b0;
				if (b > 0)
					mosi <= tx_b[i][b - 1];
				else if (i + 1 < n)
					mosi <= tx_b[i + 1][7];
				else
					mosi <= ~mosi;
			end
		end
		half();
		csn <= 1'b1;
		half();
	endtask : xfer
endmodule : rsc_host
`default_nettype wire

// file: sim/rsc_spi_core_tb_top.sv
// self-checking bench for the spi command interpreter
`timescale 1ns/1ps
`default_nettype none
module rsc_spi_core_tb_top
	import rsc_pkg::*;
;
	logic clock, rst, sck, csn, mosi, miso, miso_oe, irq_n;
	logic [3:0] ev_q; // pop, retry, received, sent
	logic [2:0] ev_pipe, tx_head_pipe;
	logic radio_idle, rx_byte, rx_commit, tx_head_noack, tx_ready;
	logic [7:0] rx_byte_data, tx_head_data, config_out;
	logic [5:0] pipe_lost, tx_head_len;
	logic [4:0] tx_head_index;
	logic tx_stalled, reuse_active, radio_hold, features_on, bank_sel;
	logic [3:0] ev_tab [0:2] = '{4'h2, 4'h1, 4'h4};
	int fail_count;
	int checked;
	rsc_spi_core i_dut (
		.clock, .rst, .sck, .csn, .mosi, .miso, .miso_oe, .irq_n,
		.ev_sent(ev_q[0]), .ev_received(ev_q[1]), .ev_pipe,
		.ev_retry_limit(ev_q[2]), .radio_idle, .tx_pop(ev_q[3]),
		.rx_byte, .rx_byte_data, .rx_commit, .pipe_lost, .tx_head_data,
		.tx_head_index, .tx_head_len, .tx_head_noack, .tx_head_pipe,
		.tx_ready, .tx_stalled, .reuse_active, .radio_hold,
		.features_on, .bank_sel, .config_out
	);
	rsc_host i_host (.clock, .sck, .csn, .mosi, .miso);
	task automatic finish_test();
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t byte %h, expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t flag %b, expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic settle();
		repeat (6) @(posedge clock);
		@(negedge clock);
	endtask : settle
	// command byte, then nd data bytes counting up from d0
	task automatic send(input logic [7:0] c, input int nd,
		input logic [7:0] d0);
		i_host.tx_b[0] = c;
		for (int j = 0; j < nd; j++)
			i_host.tx_b[j + 1] = d0 + 8'(j);
		i_host.xfer(nd + 1);
		settle();
	endtask : send
	task automatic pulse(input logic [3:0] e);
		@(posedge clock);
		ev_q <= e;
		@(posedge clock);
		ev_q <= 4'h0;
		settle();
	endtask : pulse
	// radio side fills one rx entry, then raises the received event
	task automatic push_rx(input int n, input logic [2:0] p);
		for (int j = 0; j < n; j++)
		begin
			@(posedge clock);
			rx_byte <= 1'b1;
			rx_byte_data <= 8'h40 + 8'(j);
			@(posedge clock);
			rx_byte <= 1'b0;
		end
		@(posedge clock);
		ev_pipe <= p;
		rx_commit <= 1'b1;
		@(posedge clock);
		rx_commit <= 1'b0;
		pulse(4'h2);
	endtask : push_rx
	task automatic wait_irq(input logic exp);
		int n;
		n = 0;
		while (irq_n !== exp && n < 40)
		begin
			@(negedge clock);
			n++;
		end
		chk1(irq_n, exp);
		if (irq_n !== exp)
			finish_test();
	endtask : wait_irq
	task automatic nop_status(input logic [7:0] exp);
		send(CMD_NOP, 0, 8'h00);
		chk8(i_host.rx_b[0], exp);
	endtask : nop_status
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial
	begin
		rst = 1'b1;
		ev_q = 4'h0;
		ev_pipe = 3'h0;
		radio_idle = 1'b1;
		rx_byte = 1'b0;
		rx_byte_data = 8'h00;
		rx_commit = 1'b0;
		pipe_lost = 6'h00;
		tx_head_index = 5'h00;
		fail_count = 0;
		checked = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		settle();
		chk1(irq_n, 1'b1);
		chk1(miso_oe, 1'b0);
		chk8(config_out, CONFIG_RESET);
		nop_status(8'h0E);
		send(CMD_RD_REG + 8'(REG_CONFIG), 1, 8'h00);
		chk8(i_host.rx_b[1], CONFIG_RESET);
		send(CMD_WR_REG + 8'(REG_CONFIG), 1, 8'h0A);
		@(posedge clock);
		radio_idle <= 1'b0;
		send(CMD_WR_REG + 8'(REG_CONFIG), 1, 8'h08);
		chk8(config_out, 8'h0A);
		@(posedge clock);
		radio_idle <= 1'b1;
		send(CMD_WR_REG + 8'(REG_CONFIG), 1, 8'h08);
		chk8(config_out, 8'h08);
		send(CMD_WR_REG + 8'h0A, 5, 8'h51);
		send(CMD_RD_REG + 8'h0A, 5, 8'h00);
		for (int j = 0; j < 5; j++)
			chk8(i_host.rx_b[j + 1], 8'h51 + 8'(j));
		send(CMD_ACTIVATE, 1, ACT_BANK);
		chk1(bank_sel, 1'b1);
		nop_status(8'h8E);
		send(CMD_ACTIVATE, 1, ACT_BANK);
		push_rx(4, 3'h2);
		wait_irq(1'b0);
		nop_status(8'h44);
		send(CMD_RD_WID, 1, 8'h00);
		chk8(i_host.rx_b[1], 8'h00);
		send(CMD_ACTIVATE, 1, ACT_FEATURES);
		chk1(features_on, 1'b1);
		send(CMD_RD_WID, 1, 8'h00);
		chk8(i_host.rx_b[1], 8'h04);
		send(CMD_RD_RX, 4, 8'h00);
		for (int j = 0; j < 4; j++)
			chk8(i_host.rx_b[j + 1], 8'h40 + 8'(j));
		nop_status(8'h4E);
		send(CMD_WR_REG + 8'(REG_STATUS), 1, 8'h40);
		wait_irq(1'b1);
		push_rx(2, 3'h5);
		send(CMD_FLUSH_RX, 0, 8'h00);
		send(CMD_WR_REG + 8'(REG_STATUS), 1, 8'h40);
		nop_status(8'h0E);
		for (int k = 0; k < 3; k++)
		begin
			send(CMD_WR_REG + 8'(REG_CONFIG), 1, 8'h08 | (8'h40 >> k));
			pulse(ev_tab[k]);
			chk1(irq_n, 1'b1);
			send(CMD_WR_REG + 8'(REG_CONFIG), 1, 8'h08);
			wait_irq(1'b0);
			send(CMD_WR_REG + 8'(REG_STATUS), 1, 8'h40 >> k);
			wait_irq(1'b1);
		end
		send(CMD_WR_TX, 3, 8'h10);
		chk8({2'b00, tx_head_len}, 8'h03);
		@(posedge clock);
		tx_head_index <= 5'h01;
		settle();
		chk8(tx_head_data, 8'h11);
		pulse(4'h4);
		pulse(4'h8);
		chk8({2'b00, tx_head_len}, 8'h03);
		chk1(tx_ready, 1'b0);
		chk1(radio_hold, 1'b1);
		send(CMD_WR_REG + 8'(REG_STATUS), 1, 8'h10);
		chk1(radio_hold, 1'b0);
		chk1(tx_ready, 1'b1);
		pulse(4'h8);
		chk1(tx_ready, 1'b0);
		for (int k = 0; k < 3; k++)
			send(CMD_WR_TX, 32, 8'h00);
		nop_status(8'h0F);
		send(CMD_REUSE, 0, 8'h00);
		chk1(reuse_active, 1'b1);
		send(CMD_FLUSH_TX, 0, 8'h00);
		chk1(tx_ready, 1'b0);
		chk1(reuse_active, 1'b0);
		send(CMD_REUSE, 0, 8'h00);
		send(CMD_WR_TX, 1, 8'h00);
		chk1(reuse_active, 1'b0);
		send(CMD_FLUSH_TX, 0, 8'h00);
		send(CMD_WR_NOACK, 2, 8'h00);
		chk1(tx_head_noack, 1'b1);
		send(CMD_FLUSH_TX, 0, 8'h00);
		send(CMD_WR_ACK + 8'h01, 2, 8'h00);
		chk8({5'h00, tx_head_pipe}, 8'h01);
		@(posedge clock);
		pipe_lost <= 6'h02;
		settle();
		chk1(tx_stalled, 1'b1);
		send(CMD_FLUSH_TX, 0, 8'h00);
		chk1(tx_stalled, 1'b0);
		// mid-run reset must drop bank, features and config writes
		send(CMD_WR_REG + 8'(REG_CONFIG), 1, 8'h78);
		send(CMD_ACTIVATE, 1, ACT_BANK);
		chk1(bank_sel, 1'b1);
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		settle();
		chk8(config_out, CONFIG_RESET);
		chk1(features_on, 1'b0);
		nop_status(8'h0E);
		finish_test();
	end
endmodule : rsc_spi_core_tb_top
`default_nettype wire
